/* design/efiu_event_flag_unit.sv */
/*
 * Event flag interrupt unit: twelve latched event flags, a matching enable
 * mask and an active-low interrupt request pin towards the host.
 * Assumes the serial frame decoder on the same clock presents register
 * reads, read-and-clear and writes as single-cycle strobes with an index.
 */
// Functional notes
// - Event drives interrupt pin only when its enable bit is high.
// - All enable mask bits clear to low on every reset.
// - Each flag shares its bit position with its enable bit.
// - Read-and-clear of flags services requests and clears flags.
// - Plain read leaves flags and pending requests unchanged.
// - Time-out flags survive read-and-clear while time-out persists.
// - Separate time-out flags for high-speed and both single-wire inputs.
// - High-speed time-out flag clearable once its mode leaves normal.
// - Single-wire time-out flags clearable once their mode leaves normal.
// - Whole flag register clears to zero on every reset.
// - Step-down no-regulation flag sets on any change of its signal.
// - Step-down overload flag sets on any change of its signal.
// - Step-up toggle flag sets on activation or deactivation.
// - Step-up overload flag sets on any change of its signal.
// - Thermal warning flag sets on crossing in either direction.
// - Bad watchdog service flags only in debug configuration, else resets.
// - Aux under-voltage crossing flagged only while aux regulator is on.
// - Aux over-voltage flag sets on crossing in either direction.
// - Frame failure flag sets on every malformed serial frame.
// - Power-up chip-select toggling only affects the frame failure flag.
module efiu_event_flag_unit
    import efiu_pkg::*;
(
    input  wire logic                   core_clk_in,
    input  wire logic                   reset_in,
    // Register access from the serial frame decoder (same clock)
    input  wire logic                   reg_write_in,
    input  wire logic                   reg_read_in,
    input  wire logic                   reg_read_clear_in,
    input  wire logic [2:0]             reg_addr_in,
    input  wire logic [EFIU_DATA_W-1:0] reg_wdata_in,
    output logic      [EFIU_DATA_W-1:0] reg_rdata_out,
    // Dominant time-out conditions (same clock, level while persisting)
    input  wire logic                   hs_timeout_in,
    input  wire logic                   sw1_timeout_in,
    input  wire logic                   sw2_timeout_in,
    input  wire logic [1:0]             hs_mode_in,
    input  wire logic [1:0]             sw1_mode_in,
    input  wire logic [1:0]             sw2_mode_in,
    // Converter, thermal and aux supply comparators (asynchronous levels)
    input  wire logic                   step_down_noreg_in,
    input  wire logic                   step_down_overload_in,
    input  wire logic                   step_up_running_in,
    input  wire logic                   step_up_overload_in,
    input  wire logic                   thermal_warn_in,
    input  wire logic                   aux_undervolt_in,
    input  wire logic                   aux_overvolt_in,
    input  wire logic                   aux_regulator_on_in,
    // Watchdog and serial events (same clock, one-cycle pulses)
    input  wire logic                   wdog_bad_service_in,
    input  wire logic                   software_debug_configuration_in,
    input  wire logic                   frame_fail_in,
    output logic                        wdog_reset_req_out,
    output logic                        interrupt_request_pin_n_out,
    output logic      [EFIU_DATA_W-1:0] event_flags_out
);

    logic [EFIU_DATA_W-1:0]     enable_mask_r;
    logic [EFIU_DATA_W-1:0]     event_flags_r;
    logic [EFIU_DATA_W-1:0]     event_flags_nxt;
    logic [EFIU_DATA_W-1:0]     set_vec;
    logic [EFIU_DATA_W-1:0]     hold_vec;
    logic [EFIU_DATA_W-1:0]     rdata_r;
    logic                       irq_n_r;
    logic                       wdog_reset_r;
    logic [EFIU_NUM_LEVELS-1:0] lvl_sync;
    logic [EFIU_NUM_LEVELS-1:0] lvl_change;
    logic                       clear_hit;
    logic                       hs_not_normal;
    logic                       sw1_not_normal;
    logic                       sw2_not_normal;

    ////////////////////////////////////////////////////////////////////////
    // Comparator levels enter through a synchroniser and change detector
    efiu_level_sync u_level_sync (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .level_in    ({aux_overvolt_in,
                       aux_undervolt_in,
                       thermal_warn_in,
                       step_up_overload_in,
                       step_up_running_in,
                       step_down_overload_in,
                       step_down_noreg_in}),
        .level_out   (lvl_sync),
        .change_out  (lvl_change)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event set terms, each at its flag's shared bit position
    always_comb begin
        set_vec                      = EFIU_ZERO12;
        // Out of normal mode a persisting time-out no longer re-sets its flag
        set_vec[EFIU_BIT_HS_TO]      = hs_timeout_in & ~hs_not_normal;
        set_vec[EFIU_BIT_SW1_TO]     = sw1_timeout_in & ~sw1_not_normal;
        set_vec[EFIU_BIT_SW2_TO]     = sw2_timeout_in & ~sw2_not_normal;
        set_vec[EFIU_BIT_DN_NOREG]   = lvl_change[EFIU_LVL_DN_NOREG];
        set_vec[EFIU_BIT_DN_OVL]     = lvl_change[EFIU_LVL_DN_OVL];
        set_vec[EFIU_BIT_UP_TOGGLE]  = lvl_change[EFIU_LVL_UP_RUN];
        set_vec[EFIU_BIT_UP_OVL]     = lvl_change[EFIU_LVL_UP_OVL];
        set_vec[EFIU_BIT_THERM]      = lvl_change[EFIU_LVL_THERM];
        // Watchdog fault is an interrupt event only in debug configuration
        set_vec[EFIU_BIT_WDOG]       = wdog_bad_service_in
                                       & software_debug_configuration_in;
        // Under-voltage comparator is meaningless with the regulator off
        set_vec[EFIU_BIT_AUX_UV]     = lvl_change[EFIU_LVL_AUX_UV]
                                       & aux_regulator_on_in;
        set_vec[EFIU_BIT_AUX_OV]     = lvl_change[EFIU_LVL_AUX_OV];
        set_vec[EFIU_BIT_FRAME_FAIL] = frame_fail_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // Time-out flags refuse the clear while the condition persists in normal
    assign hs_not_normal  = (hs_mode_in  != EFIU_MODE_NORMAL);
    assign sw1_not_normal = (sw1_mode_in != EFIU_MODE_NORMAL);
    assign sw2_not_normal = (sw2_mode_in != EFIU_MODE_NORMAL);

    always_comb begin
        hold_vec                 = EFIU_ZERO12;
        hold_vec[EFIU_BIT_HS_TO] = hs_timeout_in & ~hs_not_normal;
        hold_vec[EFIU_BIT_SW1_TO] = sw1_timeout_in & ~sw1_not_normal;
        hold_vec[EFIU_BIT_SW2_TO] = sw2_timeout_in & ~sw2_not_normal;
    end

    // Only a read-and-clear of the flag register counts as service
    assign clear_hit = reg_read_clear_in & (reg_addr_in == EFIU_ADDR_EVENT_FLAGS);

    ////////////////////////////////////////////////////////////////////////
    // Flag next value; a set arriving with the clear wins so nothing is lost
    always_comb begin
        if (clear_hit) begin
            event_flags_nxt = (event_flags_r & hold_vec) | set_vec;
        end else begin
            event_flags_nxt = event_flags_r | set_vec;
        end
    end

    // Flag register; only reset or the serial clear strobe removes a flag
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            event_flags_r <= EFIU_FLAGS_RESET;
        end else begin
            event_flags_r <= event_flags_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable mask, written by the host
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            enable_mask_r <= EFIU_MASK_RESET;
        end else if (reg_write_in && (reg_addr_in == EFIU_ADDR_ENABLE_MASK)) begin
            enable_mask_r <= reg_wdata_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data registered; flag read shows value before any clear
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rdata_r <= EFIU_ZERO12;
        end else if (reg_read_in || reg_read_clear_in) begin
            case (reg_addr_in)
                EFIU_ADDR_ENABLE_MASK: rdata_r <= enable_mask_r;
                EFIU_ADDR_EVENT_FLAGS: rdata_r <= event_flags_r;
                default:               rdata_r <= EFIU_ZERO12;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pin, low while any enabled flag is set
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= ~|(event_flags_nxt & enable_mask_r);
        end
    end

    // Outside debug configuration a bad watchdog service asks for reset
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            wdog_reset_r <= 1'b0;
        end else begin
            wdog_reset_r <= wdog_bad_service_in & ~software_debug_configuration_in;
        end
    end

    assign reg_rdata_out               = rdata_r;
    assign interrupt_request_pin_n_out = irq_n_r;
    assign wdog_reset_req_out          = wdog_reset_r;
    assign event_flags_out             = event_flags_r;

endmodule : efiu_event_flag_unit

/* design/efiu_pkg.sv */
/*
 * Package for the event flag interrupt unit: register indices, flag bit
 * positions, reset values and transceiver mode codes.
 * Assumes a single 25 MHz core clock and a synchronous active-high reset.
 */
package efiu_pkg;

    localparam int unsigned EFIU_DATA_W = 12;

    // Register indices as the serial interface presents them
    localparam logic [2:0] EFIU_ADDR_ENABLE_MASK = 3'h3;
    localparam logic [2:0] EFIU_ADDR_EVENT_FLAGS = 3'h4;

    // Flag and enable bit positions (shared by both registers)
    localparam int unsigned EFIU_BIT_HS_TO       = 0;
    localparam int unsigned EFIU_BIT_SW1_TO      = 1;
    localparam int unsigned EFIU_BIT_SW2_TO      = 2;
    localparam int unsigned EFIU_BIT_DN_NOREG    = 3;
    localparam int unsigned EFIU_BIT_DN_OVL      = 4;
    localparam int unsigned EFIU_BIT_UP_TOGGLE   = 5;
    localparam int unsigned EFIU_BIT_UP_OVL      = 6;
    localparam int unsigned EFIU_BIT_THERM       = 7;
    localparam int unsigned EFIU_BIT_WDOG        = 8;
    localparam int unsigned EFIU_BIT_AUX_UV      = 9;
    localparam int unsigned EFIU_BIT_AUX_OV      = 10;
    localparam int unsigned EFIU_BIT_FRAME_FAIL  = 11;

    // Reset contents
    localparam logic [11:0] EFIU_MASK_RESET  = 12'h000;
    localparam logic [11:0] EFIU_FLAGS_RESET = 12'h000;
    localparam logic [11:0] EFIU_ZERO12      = 12'h000;

    // Transceiver mode code meaning normal operation
    localparam logic [1:0]  EFIU_MODE_NORMAL = 2'h3;

    // Level inputs sampled through synchronisers, in this order
    localparam int unsigned EFIU_NUM_LEVELS  = 7;
    localparam int unsigned EFIU_LVL_DN_NOREG = 0;
    localparam int unsigned EFIU_LVL_DN_OVL   = 1;
    localparam int unsigned EFIU_LVL_UP_RUN   = 2;
    localparam int unsigned EFIU_LVL_UP_OVL   = 3;
    localparam int unsigned EFIU_LVL_THERM    = 4;
    localparam int unsigned EFIU_LVL_AUX_UV   = 5;
    localparam int unsigned EFIU_LVL_AUX_OV   = 6;

endpackage : efiu_pkg

/* design/efiu_level_sync.sv */
/*
 * Two-flop synchroniser with change detector for a group of level inputs.
 * Assumes inputs arrive from analogue comparators outside the clock domain.
 * The first stage is read by the second only; changes are seen on stages 2/3.
 */
module efiu_level_sync
    import efiu_pkg::*;
(
    input  wire logic                       core_clk_in,
    input  wire logic                       reset_in,
    input  wire logic [EFIU_NUM_LEVELS-1:0] level_in,
    output logic      [EFIU_NUM_LEVELS-1:0] level_out,
    output logic      [EFIU_NUM_LEVELS-1:0] change_out
);

    logic [EFIU_NUM_LEVELS-1:0] meta_r;
    logic [EFIU_NUM_LEVELS-1:0] sync_r;
    logic [EFIU_NUM_LEVELS-1:0] prev_r;
    logic [2:0]                 primed_r;

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser chain; history seeded after reset so no false edge
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            meta_r   <= '0;
            sync_r   <= '0;
            prev_r   <= '0;
            primed_r <= 3'h0;
        end else begin
            meta_r   <= level_in;
            sync_r   <= meta_r;
            prev_r   <= sync_r;
            primed_r <= {primed_r[1:0], 1'b1};
        end
    end

    // Either-direction change, suppressed until both stages hold real samples,
    // so a comparator already high across reset gives no false edge
    assign change_out = primed_r[2] ? (sync_r ^ prev_r) : '0;
    assign level_out  = sync_r;

endmodule : efiu_level_sync

/* testbench/efiu_props.sv */
/* Port checker for the event flag interrupt unit.
   Assumes a bind onto efiu_event_flag_unit; single clock, sync reset. */
module efiu_props
    import efiu_pkg::*;
(
    input wire logic                   core_clk_in,
    input wire logic                   reset_in,
    input wire logic                   reg_read_in,
    input wire logic                   reg_read_clear_in,
    input wire logic [2:0]             reg_addr_in,
    input wire logic [EFIU_DATA_W-1:0] reg_rdata_out,
    input wire logic                   hs_timeout_in,
    input wire logic                   sw1_timeout_in,
    input wire logic                   sw2_timeout_in,
    input wire logic [1:0]             hs_mode_in,
    input wire logic                   wdog_bad_service_in,
    input wire logic                   software_debug_configuration_in,
    input wire logic                   frame_fail_in,
    input wire logic                   wdog_reset_req_out,
    input wire logic                   interrupt_request_pin_n_out,
    input wire logic [EFIU_DATA_W-1:0] event_flags_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////////////
    // Reset is checked with its own disable, since it is the cause here
    property p_rst;
        disable iff (1'b0) reset_in |=> event_flags_out == EFIU_FLAGS_RESET
            && interrupt_request_pin_n_out && !wdog_reset_req_out;
    endproperty
    a_rst: assert property (p_rst) else $error("reset contents wrong");
    // Only same-clock sources can refill bits 0..2 and 11 after a clear
    property p_clr;
        reg_read_clear_in && reg_addr_in == EFIU_ADDR_EVENT_FLAGS && !hs_timeout_in
            && !sw1_timeout_in && !sw2_timeout_in && !frame_fail_in
            |=> event_flags_out[2:0] == 3'h0 && !event_flags_out[11];
    endproperty
    a_clr: assert property (p_clr) else $error("flags not cleared");
    property p_keep;
        reg_read_in && !reg_read_clear_in |=>
            (event_flags_out & $past(event_flags_out)) == $past(event_flags_out);
    endproperty
    a_keep: assert property (p_keep) else $error("plain read lost a flag");
    property p_rdata;
        (reg_read_in || reg_read_clear_in) && reg_addr_in == EFIU_ADDR_EVENT_FLAGS
            |=> reg_rdata_out == $past(event_flags_out);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data wrong");
    property p_to;
        hs_timeout_in && hs_mode_in == EFIU_MODE_NORMAL |=> event_flags_out[0];
    endproperty
    a_to: assert property (p_to) else $error("time-out flag dropped");
    property p_ff;
        frame_fail_in |=> event_flags_out[11];
    endproperty
    a_ff: assert property (p_ff) else $error("frame failure not flagged");
    property p_wdr;
        wdog_bad_service_in && !software_debug_configuration_in |=> wdog_reset_req_out;
    endproperty
    a_wdr: assert property (p_wdr) else $error("no watchdog reset");
    property p_wdf;
        wdog_bad_service_in && software_debug_configuration_in
            |=> event_flags_out[8] && !wdog_reset_req_out;
    endproperty
    a_wdf: assert property (p_wdf) else $error("debug watchdog event wrong");
    property p_irq;
        !interrupt_request_pin_n_out |-> event_flags_out != EFIU_ZERO12;
    endproperty
    a_irq: assert property (p_irq) else $error("request without flag");
    // Main scenarios
    c_clr: cover property (reg_read_clear_in && event_flags_out != EFIU_ZERO12);
    c_irq: cover property ($fell(interrupt_request_pin_n_out));
    c_wdr: cover property (wdog_reset_req_out);
endmodule : efiu_props

/* testbench/efiu_host_model.sv */
/* Host side model: the view of the flags that the host acts upon.
   Assumes flags and clear strobe come straight from the unit. */
module efiu_host_model
    import efiu_pkg::*;
(
    input  wire logic                   core_clk_in,
    input  wire logic                   reset_in,
    input  wire logic                   reg_read_clear_in,
    input  wire logic [EFIU_DATA_W-1:0] event_flags_in,
    output logic      [EFIU_DATA_W-1:0] flags_view_out
);
    logic trust_r;
    // Power-up transients may fake a frame failure until the first clear
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            trust_r <= 1'b0;
        end else if (reg_read_clear_in) begin
            trust_r <= 1'b1;
        end
    end
    assign flags_view_out = event_flags_in & ~{~trust_r, 11'h000};
endmodule : efiu_host_model

/* testbench/testbench.sv */
/* Self-checking bench for the event flag interrupt unit.
   Assumes the unit and the host model; inputs change at falling edges. */
module testbench;
    import efiu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rc = 1'b0;
    logic        aux_on = 1'b0, wdog = 1'b0, dbg = 1'b0, ff = 1'b0, wrq, pin_n;
    logic [2:0]  addr = 3'h0, to = 3'h0;
    logic [1:0]  md = EFIU_MODE_NORMAL;
    logic [6:0]  lvl = 7'h00;
    logic [11:0] wd = 12'h000, rdata, flags, view;
    int          error_cnt = 0, total_checks = 0;
    int          fb[7] = '{3, 4, 5, 6, 7, 9, 10};
    always #20 clk = ~clk;
    efiu_event_flag_unit dut_u (.core_clk_in(clk), .reset_in(rst), .reg_write_in(wr),
        .reg_read_in(rd), .reg_read_clear_in(rc), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_rdata_out(rdata), .hs_timeout_in(to[0]), .sw1_timeout_in(to[1]),
        .sw2_timeout_in(to[2]), .hs_mode_in(md), .sw1_mode_in(md), .sw2_mode_in(md),
        .step_down_noreg_in(lvl[0]), .step_down_overload_in(lvl[1]),
        .step_up_running_in(lvl[2]), .step_up_overload_in(lvl[3]),
        .thermal_warn_in(lvl[4]), .aux_undervolt_in(lvl[5]), .aux_overvolt_in(lvl[6]),
        .aux_regulator_on_in(aux_on), .wdog_bad_service_in(wdog),
        .software_debug_configuration_in(dbg), .frame_fail_in(ff),
        .wdog_reset_req_out(wrq), .interrupt_request_pin_n_out(pin_n),
        .event_flags_out(flags));
    efiu_host_model host_u (.core_clk_in(clk), .reset_in(rst), .reg_read_clear_in(rc),
        .event_flags_in(flags), .flags_view_out(view));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Kind 0 write, 1 read, 2 read-and-clear; one-cycle strobe
    task automatic acc(input int k, input logic [2:0] a, input logic [11:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        {wr, rd, rc} = 3'h4 >> k;
        @(negedge clk);
        {wr, rd, rc} = 3'h0;
    endtask : acc
    task automatic stop_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    // Whole run is about 185 cycles; generous margin
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk("flags_rst", flags, 12'h000);
        acc(1, 3'h3, 12'h000);
        chk("mask_rst", rdata, 12'h000);
        ff = 1'b1;
        @(negedge clk) ff = 1'b0;
        chk("pin_masked", 12'(pin_n), 12'h001);
        acc(1, 3'h4, 12'h000);
        chk("rd_flags", rdata, 12'h800);
        chk("flags_kept", flags, 12'h800);
        chk("host_view", view, 12'h000);
        acc(0, 3'h3, 12'h800);
        acc(0, 3'h4, 12'hfff);
        chk("pin_enabled", 12'(pin_n), 12'h000);
        acc(1, 3'h3, 12'h000);
        chk("mask_rd", rdata, 12'h800);
        acc(1, 3'h7, 12'h000);
        chk("unmapped", rdata, 12'h000);
        acc(2, 3'h4, 12'h000);
        chk("rc_data", rdata, 12'h800);
        chk("rc_flags", flags, 12'h000);
        chk("rc_pin", 12'(pin_n), 12'h001);
        aux_on = 1'b1;
        // Both directions of every comparator crossing
        for (int p = 0; p < 14; p++) begin
            acc(0, 3'h3, 12'h001 << fb[p % 7]);
            lvl[p % 7] = ~lvl[p % 7];
            repeat (5) @(negedge clk);
            chk("lvl_flag", flags, 12'h001 << fb[p % 7]);
            chk("lvl_pin", 12'(pin_n), 12'h000);
            acc(2, 3'h4, 12'h000);
        end
        aux_on = 1'b0;
        lvl[5] = 1'b1;
        repeat (5) @(negedge clk);
        chk("uv_off", flags, 12'h000);
        acc(0, 3'h3, 12'h007);
        for (int i = 0; i < 3; i++) begin
            to[i] = 1'b1;
            repeat (2) @(negedge clk);
            chk("to_set", flags, 12'h001 << i);
            acc(2, 3'h4, 12'h000);
            chk("to_held", flags, 12'h001 << i);
            chk("to_pin", 12'(pin_n), 12'h000);
            to[i] = 1'b0;
            acc(2, 3'h4, 12'h000);
            chk("to_gone", flags, 12'h000);
        end
        to = 3'h7;
        repeat (2) @(negedge clk);
        chk("to_all", flags, 12'h007);
        md = 2'h2;
        acc(2, 3'h4, 12'h000);
        chk("to_mode_clr", flags, 12'h000);
        chk("to_mode_pin", 12'(pin_n), 12'h001);
        to = 3'h0;
        md = EFIU_MODE_NORMAL;
        dbg = 1'b1;
        wdog = 1'b1;
        @(negedge clk) wdog = 1'b0;
        chk("wd_dbg", flags, 12'h100);
        chk("wd_norst", 12'(wrq), 12'h000);
        acc(2, 3'h4, 12'h000);
        dbg = 1'b0;
        wdog = 1'b1;
        @(negedge clk) wdog = 1'b0;
        chk("wd_rst", 12'(wrq), 12'h001);
        chk("wd_noflag", flags, 12'h000);
        ff = 1'b1;
        @(negedge clk) ff = 1'b0;
        chk("host_view2", view, 12'h800);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk("flags_rst2", flags, 12'h000);
        acc(1, 3'h3, 12'h000);
        chk("mask_rst2", rdata, 12'h000);
        stop_test();
    end
endmodule : testbench
bind efiu_event_flag_unit efiu_props props_u (.core_clk_in(core_clk_in),
    .reset_in(reset_in), .reg_read_in(reg_read_in), .reg_read_clear_in(reg_read_clear_in),
    .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out), .hs_timeout_in(hs_timeout_in),
    .sw1_timeout_in(sw1_timeout_in), .sw2_timeout_in(sw2_timeout_in),
    .hs_mode_in(hs_mode_in), .wdog_bad_service_in(wdog_bad_service_in),
    .software_debug_configuration_in(software_debug_configuration_in),
    .frame_fail_in(frame_fail_in), .wdog_reset_req_out(wdog_reset_req_out),
    .interrupt_request_pin_n_out(interrupt_request_pin_n_out),
    .event_flags_out(event_flags_out));
